// File: tscu_pkg.sv
package tscu_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int TEMP_W = 13;

    localparam logic [7:0] ADDR_CAPABILITY = 8'h00;
    localparam logic [7:0] ADDR_THERMAL_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_UPPER_BOUND = 8'h02;
    localparam logic [7:0] ADDR_LOWER_BOUND = 8'h03;
    localparam logic [7:0] ADDR_CRIT_BOUND = 8'h04;
    localparam logic [7:0] ADDR_TEMP_RESULT = 8'h05;

    localparam logic [15:0] CAPABILITY_VALUE = 16'h0037;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [12:0] BOUND_RESET = 13'h0000;

    localparam int HYST_MSB = 10;
    localparam int HYST_LSB = 9;
    localparam int SHUTDOWN_BIT = 8;
    localparam int CRIT_LOCK_BIT = 7;
    localparam int WINDOW_LOCK_BIT = 6;
    localparam int CLEAR_EVENT_BIT = 5;
    localparam int EVENT_STAT_BIT = 4;
    localparam int EVENT_EN_BIT = 3;
    localparam int CRIT_ONLY_BIT = 2;
    localparam int POL_BIT = 1;
    localparam int MODE_BIT = 0;

    localparam int CRIT_FLAG_BIT = 15;
    localparam int ABOVE_FLAG_BIT = 14;
    localparam int BELOW_FLAG_BIT = 13;

    // Hysteresis amounts in temperature LSBs of 0.0625 degrees.
    localparam logic [1:0] HYST_OFF = 2'h0;
    localparam logic [1:0] HYST_1P5 = 2'h1;
    localparam logic [1:0] HYST_3 = 2'h2;
    localparam logic [1:0] HYST_6 = 2'h3;
    localparam logic [7:0] HYST_LSB_1P5 = 8'h18;
    localparam logic [7:0] HYST_LSB_3 = 8'h30;
    localparam logic [7:0] HYST_LSB_6 = 8'h60;

    function automatic logic [7:0] tscu_hyst_amount(input logic [1:0] sel);
        logic [7:0] amt;
        amt = 8'h00;
        unique case (sel)
            HYST_OFF: amt = 8'h00;
            HYST_1P5: amt = HYST_LSB_1P5;
            HYST_3: amt = HYST_LSB_3;
            HYST_6: amt = HYST_LSB_6;
        endcase
        return amt;
    endfunction : tscu_hyst_amount
endpackage : tscu_pkg

// File: tscu_window.sv
module tscu_window
    import tscu_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Comparison inputs.
    input wire logic latch,
    input wire logic signed [tscu_pkg::TEMP_W-1:0] temp,
    input wire logic signed [tscu_pkg::TEMP_W-1:0] upper,
    input wire logic signed [tscu_pkg::TEMP_W-1:0] lower,
    input wire logic [1:0] hyst_sel,
    // Window flags.
    output logic above,
    output logic below
);
    logic above_q, above_d, below_q, below_d;
    logic signed [TEMP_W+1:0] t_x, up_rel, lo_set, hyst_x;

    // Two guard bits keep boundary minus hysteresis from wrapping.
    always_comb begin
        t_x = (TEMP_W + 2)'(temp);
        hyst_x = $signed((TEMP_W + 2)'(tscu_hyst_amount(hyst_sel)));
        up_rel = (TEMP_W + 2)'(upper) - hyst_x;
        lo_set = (TEMP_W + 2)'(lower) - hyst_x;
        above_d = above_q;
        below_d = below_q;
        if (latch) begin
            if (t_x > (TEMP_W + 2)'(upper)) begin
                above_d = 1'b1;
            end else if (t_x <= up_rel) begin
                above_d = 1'b0;
            end
            if (t_x >= (TEMP_W + 2)'(lower)) begin
                below_d = 1'b0;
            end else if (t_x <= lo_set) begin
                below_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            above_q <= 1'b0;
            below_q <= 1'b0;
        end else begin
            above_q <= above_d;
            below_q <= below_d;
        end
    end

    assign above = above_q;
    assign below = below_q;
endmodule : tscu_window

// File: tscu_top.sv
module tscu_top
    import tscu_pkg::*;
#(
    parameter int TEMP_BITS = 13
) (
    // Clock and power-on reset.
    input wire logic REF_CLK,
    input wire logic RST,
    // Register access from the serial engine.
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [tscu_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tscu_pkg::DATA_W-1:0] REG_WDATA,
    output logic [tscu_pkg::DATA_W-1:0] REG_RDATA,
    // Converter.
    input wire logic CONV_VALID,
    input wire logic [tscu_pkg::TEMP_W-1:0] CONV_DATA,
    output logic CONV_RUN,
    // Alert.
    output logic EVENT_ACTIVE
);
    import tscu_pkg::*;

    // The compare logic serves only the documented result width.
    if (TEMP_BITS != TEMP_W) begin : g_bad_width
        $error("tscu_top supports only TEMP_BITS equal to TEMP_W");
    end

    logic [1:0] hyst_q, hyst_d;
    logic shutdown_q, shutdown_d;
    logic crit_lock_q, crit_lock_d;
    logic win_lock_q, win_lock_d;
    logic evt_en_q, evt_en_d;
    logic crit_only_q, crit_only_d;
    logic [1:0] low_bits_q, low_bits_d;
    logic [TEMP_W-1:0] upper_q, upper_d;
    logic [TEMP_W-1:0] lower_q, lower_d;
    logic [TEMP_W-1:0] crit_q, crit_d;
    logic [TEMP_W-1:0] temp_q, temp_d;
    logic crit_flag_q, crit_flag_d;
    logic latched_q, latched_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic run_q, run_d;
    logic event_q, event_d;
    logic any_lock, cfg_wr, conv_take;
    logic above, below;

    assign any_lock = crit_lock_q | win_lock_q;
    assign cfg_wr = REG_WR && (REG_ADDR == ADDR_THERMAL_CONFIG);
    // While shut down the converter is idle, so stray results are dropped.
    assign conv_take = CONV_VALID && !shutdown_q;

    // Configuration register state.
    always_comb begin
        hyst_d = hyst_q;
        shutdown_d = shutdown_q;
        crit_lock_d = crit_lock_q;
        win_lock_d = win_lock_q;
        evt_en_d = evt_en_q;
        crit_only_d = crit_only_q;
        low_bits_d = low_bits_q;
        if (cfg_wr) begin
            // Bits 15:11 are not stored and always read back as zero.
            if (!any_lock) begin
                hyst_d = REG_WDATA[HYST_MSB:HYST_LSB];
                evt_en_d = REG_WDATA[EVENT_EN_BIT];
                crit_only_d = REG_WDATA[CRIT_ONLY_BIT];
            end
            if (!REG_WDATA[SHUTDOWN_BIT]) begin
                shutdown_d = 1'b0;
            end else if (!any_lock) begin
                shutdown_d = 1'b1;
            end
            crit_lock_d = crit_lock_q | REG_WDATA[CRIT_LOCK_BIT];
            win_lock_d = win_lock_q | REG_WDATA[WINDOW_LOCK_BIT];
            low_bits_d = {REG_WDATA[POL_BIT], REG_WDATA[MODE_BIT]};
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            hyst_q <= CONFIG_RESET[HYST_MSB:HYST_LSB];
            shutdown_q <= CONFIG_RESET[SHUTDOWN_BIT];
            crit_lock_q <= CONFIG_RESET[CRIT_LOCK_BIT];
            win_lock_q <= CONFIG_RESET[WINDOW_LOCK_BIT];
            evt_en_q <= CONFIG_RESET[EVENT_EN_BIT];
            crit_only_q <= CONFIG_RESET[CRIT_ONLY_BIT];
            low_bits_q <= CONFIG_RESET[POL_BIT:MODE_BIT];
        end else begin
            hyst_q <= hyst_d;
            shutdown_q <= shutdown_d;
            crit_lock_q <= crit_lock_d;
            win_lock_q <= win_lock_d;
            evt_en_q <= evt_en_d;
            crit_only_q <= crit_only_d;
            low_bits_q <= low_bits_d;
        end
    end

    // Boundary registers, guarded by their lock bits.
    always_comb begin
        upper_d = upper_q;
        lower_d = lower_q;
        crit_d = crit_q;
        if (REG_WR && !win_lock_q && REG_ADDR == ADDR_UPPER_BOUND) begin
            upper_d = REG_WDATA[TEMP_W-1:0];
        end
        if (REG_WR && !win_lock_q && REG_ADDR == ADDR_LOWER_BOUND) begin
            lower_d = REG_WDATA[TEMP_W-1:0];
        end
        if (REG_WR && !crit_lock_q && REG_ADDR == ADDR_CRIT_BOUND) begin
            crit_d = REG_WDATA[TEMP_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            upper_q <= BOUND_RESET;
            lower_q <= BOUND_RESET;
            crit_q <= BOUND_RESET;
        end else begin
            upper_q <= upper_d;
            lower_q <= lower_d;
            crit_q <= crit_d;
        end
    end

    // Conversion result and critical comparison.
    always_comb begin
        temp_d = temp_q;
        crit_flag_d = crit_flag_q;
        latched_d = conv_take;
        if (conv_take) begin
            temp_d = CONV_DATA;
            crit_flag_d = $signed(CONV_DATA) >= $signed(crit_q);
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            temp_q <= BOUND_RESET;
            crit_flag_q <= 1'b0;
            latched_q <= 1'b0;
        end else begin
            temp_q <= temp_d;
            crit_flag_q <= crit_flag_d;
            latched_q <= latched_d;
        end
    end

    // The window check runs one cycle after the latch, on the stored value.
    tscu_window u_window (
        .clk(REF_CLK),
        .rst(RST),
        .latch(latched_q),
        .temp($signed(temp_q)),
        .upper($signed(upper_q)),
        .lower($signed(lower_q)),
        .hyst_sel(hyst_q),
        .above(above),
        .below(below)
    );

    // Outputs and read data.
    always_comb begin
        run_d = !shutdown_q;
        // The alert follows the hysteresis-shaped window flags and the raw critical compare.
        if (shutdown_q || !evt_en_q) begin
            event_d = 1'b0;
        end else if (crit_only_q) begin
            event_d = crit_flag_q;
        end else begin
            event_d = crit_flag_q | above | below;
        end
        rdata_d = rdata_q;
        if (REG_RD) begin
            rdata_d = '0;
            unique case (REG_ADDR)
                ADDR_CAPABILITY: rdata_d = CAPABILITY_VALUE;
                ADDR_THERMAL_CONFIG: begin
                    rdata_d[HYST_MSB:HYST_LSB] = hyst_q;
                    rdata_d[SHUTDOWN_BIT] = shutdown_q;
                    rdata_d[CRIT_LOCK_BIT] = crit_lock_q;
                    rdata_d[WINDOW_LOCK_BIT] = win_lock_q;
                    rdata_d[EVENT_STAT_BIT] = event_q;
                    rdata_d[EVENT_EN_BIT] = evt_en_q;
                    rdata_d[CRIT_ONLY_BIT] = crit_only_q;
                    rdata_d[POL_BIT:MODE_BIT] = low_bits_q;
                end
                ADDR_UPPER_BOUND: rdata_d[TEMP_W-1:0] = upper_q;
                ADDR_LOWER_BOUND: rdata_d[TEMP_W-1:0] = lower_q;
                ADDR_CRIT_BOUND: rdata_d[TEMP_W-1:0] = crit_q;
                ADDR_TEMP_RESULT: begin
                    rdata_d[TEMP_W-1:0] = temp_q;
                    rdata_d[CRIT_FLAG_BIT] = crit_flag_q;
                    rdata_d[ABOVE_FLAG_BIT] = above;
                    rdata_d[BELOW_FLAG_BIT] = below;
                end
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= '0;
            run_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            run_q <= run_d;
            event_q <= event_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign CONV_RUN = run_q;
    assign EVENT_ACTIVE = event_q;
endmodule : tscu_top

// File: tscu_conv_model.sv
module tscu_conv_model (
    // Clock and converter side.
    input wire logic clk,
    input wire logic run,
    output logic valid,
    output logic [12:0] data,
    // Bench control.
    input wire logic go,
    input wire logic stray,
    input wire logic [12:0] temp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial valid = 1'b0;
    initial data = 13'h0000;
    // Off-strobe data is inverted so a stale sample shows as a wrong value.
    always @(posedge clk) begin
        valid <= go && (run || stray);
        data <= (go && (run || stray)) ? temp : ~temp;
    end
endmodule : tscu_conv_model

// File: tscu_monitor.sv
module tscu_monitor
    import tscu_pkg::*;
#(
    parameter int TEMP_BITS = 13
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RST,
    // Register port.
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [tscu_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tscu_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic [tscu_pkg::DATA_W-1:0] REG_RDATA,
    // Converter and alert.
    input wire logic CONV_VALID,
    input wire logic [tscu_pkg::TEMP_W-1:0] CONV_DATA,
    input wire logic CONV_RUN,
    input wire logic EVENT_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] lock_q, lock_d, hyst_q, hyst_d;
    logic [TEMP_BITS-1:0] tmp_q, tmp_d;
    wire cfg_wr = REG_WR && REG_ADDR == ADDR_THERMAL_CONFIG;
    always_comb begin
        lock_d = lock_q | (cfg_wr ? REG_WDATA[7:6] : 2'h0);
        hyst_d = (cfg_wr && lock_q == 2'h0) ? REG_WDATA[10:9] : hyst_q;
        tmp_d = (CONV_VALID && CONV_RUN) ? CONV_DATA : tmp_q;
    end
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            lock_q <= 2'h0;
            hyst_q <= 2'h0;
            tmp_q <= '0;
        end else begin
            lock_q <= lock_d;
            hyst_q <= hyst_d;
            tmp_q <= tmp_d;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence cfg_rd_s;
        REG_RD && REG_ADDR == ADDR_THERMAL_CONFIG;
    endsequence
    sequence run_on_s;
        ##2 CONV_RUN;
    endsequence
    rsv_read_zero_a: assert property (
        cfg_rd_s |=> REG_RDATA[15:11] == 5'h00)
        else $error("reserved config bits read nonzero");
    hyst_hold_a: assert property (
        cfg_rd_s |=> REG_RDATA[10:9] == $past(hyst_q))
        else $error("hysteresis select changed under lock");
    lock_sticky_a: assert property (
        cfg_rd_s |=> REG_RDATA[7:6] == $past(lock_q))
        else $error("lock bits lost");
    shut_set_a: assert property (
        cfg_wr && REG_WDATA[8] && lock_q == 2'h0 |-> ##2 !CONV_RUN)
        else $error("shutdown write did not stop sensor");
    shut_locked_a: assert property (
        cfg_wr && lock_q != 2'h0 && CONV_RUN |-> run_on_s)
        else $error("shutdown taken while locked");
    shut_clear_a: assert property (
        cfg_wr && !REG_WDATA[8] |-> run_on_s)
        else $error("shutdown clear not taken");
    quiet_shutdown_a: assert property (
        !CONV_RUN |-> !EVENT_ACTIVE)
        else $error("alert raised in shutdown");
    temp_latch_a: assert property (
        REG_RD && REG_ADDR == ADDR_TEMP_RESULT
        |=> REG_RDATA[12:0] == $past(tmp_q))
        else $error("temperature reading wrong");
endmodule : tscu_monitor

// File: tscu_top_test.sv
module tscu_top_test;
    import tscu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic stray = 1'b0, cv, run, ev;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [12:0] temp = 13'h0000, cd;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    // Row: hysteresis code, spare, above, below, temperature.
    logic [17:0] rows [17] = '{18'h20640, 18'h24641, 18'h24611, 18'h20610,
        18'h14641, 18'h14629, 18'h10628, 18'h34641, 18'h345e1, 18'h305e0,
        18'h04641, 18'h00640, 18'h202f1, 18'h222f0, 18'h2231f, 18'h20320,
        18'h0231f};
    tscu_top #(.TEMP_BITS(13)) i_tscu_top (.REF_CLK(clk), .RST(rst),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .CONV_VALID(cv), .CONV_DATA(cd), .CONV_RUN(run),
        .EVENT_ACTIVE(ev));
    tscu_conv_model i_tscu_conv_model (.clk(clk), .run(run), .valid(cv),
        .data(cd), .go(go), .stray(stray), .temp(temp));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Two idle cycles after each write let CONV_RUN follow the register.
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        {wr, addr, wdata} = {1'b1, a, d};
        @(negedge clk);
        wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask : wr_reg
    task automatic rd_reg(string n, logic [7:0] a, logic [15:0] m, e);
        @(negedge clk);
        {rd, addr} = {1'b1, a};
        @(negedge clk);
        rd = 1'b0;
        chk(n, e, rdata & m);
    endtask : rd_reg
    task automatic conv(input logic [12:0] t);
        @(negedge clk);
        {go, temp} = {1'b1, t};
        @(negedge clk);
        go = 1'b0;
        repeat (5) @(negedge clk);
    endtask : conv
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        @(negedge clk);
        chk("run", 16'h0001, {15'h0, run});
        rd_reg("cfg", ADDR_THERMAL_CONFIG, 16'hffff, CONFIG_RESET);
        rd_reg("unmapped", 8'h40, 16'hffff, 16'h0000);
        wr_reg(ADDR_CRIT_BOUND, 16'h0fff);
        wr_reg(ADDR_UPPER_BOUND, 16'h0640);
        wr_reg(ADDR_LOWER_BOUND, 16'h0320);
        foreach (rows[i]) begin
            wr_reg(ADDR_THERMAL_CONFIG, {5'h0, rows[i][17:16], 9'h008});
            conv(rows[i][12:0]);
            rd_reg("flags", ADDR_TEMP_RESULT, 16'h7fff, rows[i][15:0]);
            chk("alert", {15'h0, |rows[i][14:13]}, {15'h0, ev});
        end
        wr_reg(ADDR_THERMAL_CONFIG, 16'h0108);
        chk("run_off", 16'h0000, {15'h0, run});
        stray = 1'b1;
        conv(13'h0641);
        stray = 1'b0;
        rd_reg("frozen", ADDR_TEMP_RESULT, 16'h7fff, 16'h231f);
        chk("alert_off", 16'h0000, {15'h0, ev});
        wr_reg(ADDR_THERMAL_CONFIG, 16'h01c8);
        wr_reg(ADDR_THERMAL_CONFIG, 16'h00c8);
        chk("run_back", 16'h0001, {15'h0, run});
        wr_reg(ADDR_THERMAL_CONFIG, 16'h07c8);
        wr_reg(ADDR_THERMAL_CONFIG, 16'h0008);
        rd_reg("locked", ADDR_THERMAL_CONFIG, 16'h07c8, 16'h00c8);
        chk("run_lock", 16'h0001, {15'h0, run});
        @(negedge clk) rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        chk("run_rst", 16'h0000, {15'h0, run});
        chk("alert_rst", 16'h0000, {15'h0, ev});
        rd_reg("cfg_por", ADDR_THERMAL_CONFIG, 16'hffff, CONFIG_RESET);
        chk("run_por", 16'h0001, {15'h0, run});
        // Critical-only alert: the window flags alone must not raise it.
        wr_reg(ADDR_CRIT_BOUND, 16'h0640);
        wr_reg(ADDR_THERMAL_CONFIG, 16'h000c);
        conv(13'h0700);
        rd_reg("crit", ADDR_TEMP_RESULT, 16'hffff, 16'hc700);
        chk("alert_crit", 16'h0001, {15'h0, ev});
        conv(13'h0100);
        rd_reg("crit_off", ADDR_TEMP_RESULT, 16'hffff, 16'h4100);
        chk("alert_win", 16'h0000, {15'h0, ev});
        end_sim();
    end
endmodule : tscu_top_test
bind tscu_top tscu_monitor #(.TEMP_BITS(TEMP_BITS)) i_tscu_monitor (
    .REF_CLK(REF_CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CONV_VALID(CONV_VALID), .CONV_DATA(CONV_DATA), .CONV_RUN(CONV_RUN),
    .EVENT_ACTIVE(EVENT_ACTIVE));
